//--- ser_status_event_reporting.sv
// Notes on behaviour
// [R1] Operation bits: 0 CV, 1 CC, 2 off, 4 trigger wait, 5 ramp, 6 sequence.
// [R2] Questionable bits 0-5 trips and modes, bit 9 external pin shutdown.
// [R3] Status byte bit 7 is OR of enabled operation event bits.
// [R4] Status byte bit 3 is OR of enabled questionable event bits.
// [R5] Operation mask and filter values range 0 to 119; six bits meaningful.
// [R6] Questionable mask and filter values range 0 to 575.
// [R7] Status preset clears the questionable enable mask.
// [R8] Operation event bits latch filtered edges; a read returns then clears.
// [R9] Questionable event bits latch filtered edges; a read returns then clears.
// [R10] Falling filter bit set: a 1-to-0 condition change sets the event bit.
// [R11] Rising filter bit set: a 0-to-1 condition change sets the event bit.
// [R12] Both filter bits set: any change sets the event bit.
// [R13] Both filter bits clear: no change ever sets the event bit.
// [R14] Condition registers show live status; reading alters nothing.
// [R15] Mask and filter reads return the value last written.
// [R16] An edge arriving with an event read stays set.
// [R17] Unused bits read zero and ignore writes.
`timescale 1ns/1ps
`include "ser_status_map.svh"

module ser_status_event_reporting (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       reset_n,
   // Live conditions
   input  wire ser_pkg::ser_op_cond_type   opCondition,
   input  wire ser_pkg::ser_ques_cond_type quesCondition,
   // Host command port
   input  wire ser_pkg::ser_cmd_type       command,
   input  wire logic                       statusPreset,
   output      ser_pkg::ser_rsp_type       response,
   // Status byte summary bits
   output      logic [7:0]                 summaryByte
);
   import ser_pkg::*;

   localparam int GROUPS = 2;
   localparam int WIDTH  = 16;

   // ****************************************************************
   // Storage, indexed by group.
   // ****************************************************************
   logic [GROUPS-1:0][WIDTH-1:0] validMask;
   logic [GROUPS-1:0][WIDTH-1:0] liveIn;
   logic [GROUPS-1:0][WIDTH-1:0] condition;
   logic [GROUPS-1:0][WIDTH-1:0] enableMask;
   logic [GROUPS-1:0][WIDTH-1:0] eventBits;
   logic [GROUPS-1:0][WIDTH-1:0] fallFilter;
   logic [GROUPS-1:0][WIDTH-1:0] riseFilter;
   logic [GROUPS-1:0][WIDTH-1:0] passedEdge;
   logic [GROUPS-1:0][WIDTH-1:0] next_eventBits;
   logic [GROUPS-1:0]            groupHit;
   logic [WIDTH-1:0]             next_readData;

   // ****************************************************************
   // Condition inputs.
   // ****************************************************************
   // Undefined positions are forced low so they can never raise an event.
   assign validMask[`SER_GROUP_OPERATION]    = `SER_OP_VALID_MASK;
   assign validMask[`SER_GROUP_QUESTIONABLE] = `SER_QUES_VALID_MASK;
   assign liveIn[`SER_GROUP_OPERATION] =
      opCondition & `SER_OP_VALID_MASK; // see [R1] see [R17]
   assign liveIn[`SER_GROUP_QUESTIONABLE] =
      quesCondition & `SER_QUES_VALID_MASK; // see [R2] see [R17]

   // ****************************************************************
   // Per-group register chain.
   // ****************************************************************
   genvar g;
   genvar b;
   generate
      for (g = 0; g < GROUPS; g++) begin : groupChain
         assign groupHit[g] = command.valid && (command.group == g[0]);

         // The condition register is also the previous sample for edges.
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               condition[g] <= `SER_REG_RESET;
            end else begin
               condition[g] <= liveIn[g]; // see [R14]
            end
         end

         for (b = 0; b < WIDTH; b++) begin : bitFilter
            assign passedEdge[g][b] =
               (riseFilter[g][b] && liveIn[g][b] &&
                !condition[g][b]) || // see [R11] see [R12] see [R13]
               (fallFilter[g][b] && !liveIn[g][b] &&
                condition[g][b]); // see [R10] see [R12] see [R13]
         end

         // A preset and a write in one cycle: the preset wins.
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               enableMask[g] <= `SER_REG_RESET;
            end else if (statusPreset &&
                         g == `SER_GROUP_QUESTIONABLE) begin
               enableMask[g] <= `SER_REG_RESET; // see [R7]
            end else if (groupHit[g] && command.write &&
                         command.select == `SER_SEL_ENABLE) begin
               enableMask[g] <=
                  command.data & validMask[g]; // see [R5] see [R6] see [R17]
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               fallFilter[g] <= `SER_REG_RESET;
            end else if (groupHit[g] && command.write &&
                         command.select == `SER_SEL_FALL_FILTER) begin
               fallFilter[g] <=
                  command.data & validMask[g]; // see [R5] see [R6] see [R15]
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               riseFilter[g] <= `SER_REG_RESET;
            end else if (groupHit[g] && command.write &&
                         command.select == `SER_SEL_RISE_FILTER) begin
               riseFilter[g] <=
                  command.data & validMask[g]; // see [R5] see [R15]
            end
         end

         // Reading clears, but an edge in the same cycle is kept.
         always_comb begin
            if (groupHit[g] && !command.write &&
                command.select == `SER_SEL_EVENT) begin
               next_eventBits[g] = passedEdge[g]; // see [R8] see [R9] see [R16]
            end else begin
               next_eventBits[g] =
                  eventBits[g] | passedEdge[g]; // see [R8] see [R9]
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               eventBits[g] <= `SER_REG_RESET;
            end else begin
               eventBits[g] <= next_eventBits[g];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Read multiplexer.
   // ****************************************************************
   // Writes and unknown selections return nothing useful, so reads of
   // unknown selections answer zero rather than stalling the host.
   always_comb begin
      next_readData = `SER_REG_RESET;
      if (command.select == `SER_SEL_CONDITION) begin
         next_readData = condition[command.group]; // see [R14]
      end else if (command.select == `SER_SEL_ENABLE) begin
         next_readData = enableMask[command.group]; // see [R15]
      end else if (command.select == `SER_SEL_EVENT) begin
         next_readData = eventBits[command.group]; // see [R8] see [R9]
      end else if (command.select == `SER_SEL_FALL_FILTER) begin
         next_readData = fallFilter[command.group]; // see [R15]
      end else if (command.select == `SER_SEL_RISE_FILTER) begin
         next_readData = riseFilter[command.group]; // see [R15]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         response <= '0;
      end else begin
         response.valid <= command.valid && !command.write;
         if (command.valid && !command.write) begin
            response.data <= next_readData;
         end
      end
   end

   // ****************************************************************
   // Status byte summary bits.
   // ****************************************************************
   // Summaries follow the registered event bits, so they trail an
   // edge by two cycles; that keeps the output straight off a flop.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         summaryByte <= `SER_BYTE_RESET;
      end else begin
         summaryByte <= `SER_BYTE_RESET;
         summaryByte[`SER_OP_SUMMARY_BIT] <=
            |(eventBits[`SER_GROUP_OPERATION] &
              enableMask[`SER_GROUP_OPERATION]); // see [R3]
         summaryByte[`SER_QUES_SUMMARY_BIT] <=
            |(eventBits[`SER_GROUP_QUESTIONABLE] &
              enableMask[`SER_GROUP_QUESTIONABLE]); // see [R4]
      end
   end

endmodule

//--- ser_status_map.svh
`ifndef SER_STATUS_MAP_SVH
`define SER_STATUS_MAP_SVH

// ****************************************************************
// Register selection codes on the command port.
// ****************************************************************
`define SER_SEL_CONDITION   3'h0
`define SER_SEL_ENABLE      3'h1
`define SER_SEL_EVENT       3'h2
`define SER_SEL_FALL_FILTER 3'h3
`define SER_SEL_RISE_FILTER 3'h4

// ****************************************************************
// Group selection codes.
// ****************************************************************
`define SER_GROUP_OPERATION    1'h0
`define SER_GROUP_QUESTIONABLE 1'h1

// ****************************************************************
// Defined bit positions of each group.
// ****************************************************************
`define SER_OP_VALID_MASK   16'h0077
`define SER_QUES_VALID_MASK 16'h023F

// ****************************************************************
// Summary bit positions inside the status byte.
// ****************************************************************
`define SER_OP_SUMMARY_BIT   7
`define SER_QUES_SUMMARY_BIT 3

// ****************************************************************
// Reset values.
// ****************************************************************
`define SER_REG_RESET  16'h0000
`define SER_BYTE_RESET 8'h00

`endif

//--- ser_pkg.sv
package ser_pkg;

   // ****************************************************************
   // Live operation conditions, bit 0 upward.
   // ****************************************************************
   typedef struct packed {
      logic [8:0] unusedHigh;
      logic       sequenceRunning;
      logic       rampRunning;
      logic       awaitingTrigger;
      logic       unusedBit;
      logic       outputOff;
      logic       constantCurrentActive;
      logic       constantVoltageActive;
   } ser_op_cond_type;

   // ****************************************************************
   // Live questionable conditions, bit 0 upward.
   // ****************************************************************
   typedef struct packed {
      logic [5:0] unusedHigh;
      logic       externalPinShutdown;
      logic [2:0] unusedMid;
      logic       parallelProtectionDisable;
      logic       overtemperatureTrip;
      logic       constantPowerActive;
      logic       powerFailShutdown;
      logic       overcurrentTrip;
      logic       overvoltageTrip;
   } ser_ques_cond_type;

   // ****************************************************************
   // Host command and its answer.
   // ****************************************************************
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        group;
      logic [2:0]  select;
      logic [15:0] data;
   } ser_cmd_type;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } ser_rsp_type;

endpackage

//--- ser_status_monitor.sv
`timescale 1ns/1ps
`include "ser_status_map.svh"

module ser_status_monitor (
   // Clock and reset
   input wire logic                       ref_clk,
   input wire logic                       reset_n,
   // Observed ports
   input wire ser_pkg::ser_op_cond_type   opCondition,
   input wire ser_pkg::ser_ques_cond_type quesCondition,
   input wire ser_pkg::ser_cmd_type       command,
   input wire logic                       statusPreset,
   input wire ser_pkg::ser_rsp_type       response,
   input wire logic [7:0]                 summaryByte
);
   import ser_pkg::*;
   // ****************************************************************
   // Port relations.
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic rd;
   logic wrEn;
   assign rd = command.valid && !command.write;
   assign wrEn = command.valid && command.write &&
                 command.select == `SER_SEL_ENABLE;
   rsp_on_read_a: assert property (rd |=> response.valid)
      else $error("read not answered");
   rsp_no_read_a: assert property (!rd |=> !response.valid)
      else $error("answer without a read");
   byte_unused_a: assert property ((summaryByte & 8'h77) == 8'h00)
      else $error("status byte unused bit set");
   sel_high_a: assert property (rd && command.select > 3'h4
      |=> response.data == 16'h0000) else $error("bad select answered");
   op_unused_a: assert property (rd && !command.group
      |=> (response.data & ~`SER_OP_VALID_MASK) == 16'h0000)
      else $error("operation unused bit read back");
   ques_unused_a: assert property (rd && command.group
      |=> (response.data & ~`SER_QUES_VALID_MASK) == 16'h0000)
      else $error("questionable unused bit read back");
   cond_live_a: assert property ($past(reset_n) && rd && !command.group
      && command.select == `SER_SEL_CONDITION |=> response.data ==
      (16'($past(opCondition, 2)) & `SER_OP_VALID_MASK))
      else $error("condition read not live");
   preset_mask_a: assert property (statusPreset ##1
      (rd && command.group && command.select == `SER_SEL_ENABLE)
      |=> response.data == 16'h0000) else $error("preset left mask set");
   op_sum_off_a: assert property (wrEn && !command.group &&
      (command.data & `SER_OP_VALID_MASK) == 16'h0000 |-> ##2 !summaryByte[7])
      else $error("operation summary with empty mask");
   ques_sum_off_a: assert property (statusPreset |-> ##2 !summaryByte[3])
      else $error("questionable summary after preset");
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "ser_status_map.svh"

module testbench;
   import ser_pkg::*;
   logic              ref_clk = 1'b0;
   logic              reset_n = 1'b0;
   ser_op_cond_type   opCondition = '0;
   ser_ques_cond_type quesCondition = '0;
   ser_cmd_type       command = '0;
   logic              statusPreset = 1'b0;
   ser_rsp_type       response;
   logic [7:0]        summaryByte;
   int                err_count = 0;
   int                checks_done = 0;
   int                g;
   logic [15:0]       cnd[2], en[2], fl[2], rs[2], ev[2];
   logic [15:0]       expData, m, live, hit;
   logic [7:0]        expSum;
   logic              expValid = 1'b0;
   logic              armed = 1'b0;
   // ****************************************************************
   // Clock, design and reference model.
   // ****************************************************************
   always #2.5 ref_clk = ~ref_clk;
   ser_status_event_reporting ser_status_event_reporting_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .opCondition(opCondition),
      .quesCondition(quesCondition), .command(command),
      .statusPreset(statusPreset), .response(response),
      .summaryByte(summaryByte));
   function automatic logic [15:0] edges(input logic [15:0] now, old, r, f);
      return (now & ~old & r) | (~now & old & f);
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      checks_done++;
      if (got !== want) begin
         err_count++;
         $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
      end
   endtask
   // The model reads inputs before the bench's non-blocking updates land.
   always @(posedge ref_clk) begin
      if (armed) begin
         check(16'(response.valid), 16'(expValid));
         if (expValid) check(response.data, expData);
         check(16'(summaryByte), 16'(expSum));
      end
      expValid = 1'b0;
      if (!reset_n) begin
         armed = 1'b1;
         expSum = 8'h00;
         for (g = 0; g < 2; g++) {cnd[g], en[g], fl[g], rs[g], ev[g]} = '0;
      end else begin
         expSum = {|(ev[0] & en[0]), 3'h0, |(ev[1] & en[1]), 3'h0};
         g = int'(command.group);
         if (command.valid && !command.write) begin
            expValid = 1'b1;
            case (command.select)
               `SER_SEL_CONDITION: expData = cnd[g];
               `SER_SEL_ENABLE: expData = en[g];
               `SER_SEL_EVENT: expData = ev[g];
               `SER_SEL_FALL_FILTER: expData = fl[g];
               `SER_SEL_RISE_FILTER: expData = rs[g];
               default: expData = 16'h0000;
            endcase
         end
         for (g = 0; g < 2; g++) begin
            m = g ? `SER_QUES_VALID_MASK : `SER_OP_VALID_MASK;
            live = (g ? 16'(quesCondition) : 16'(opCondition)) & m;
            hit = edges(live, cnd[g], rs[g], fl[g]);
            ev[g] = expValid && command.select == `SER_SEL_EVENT &&
                    int'(command.group) == g ? hit : ev[g] | hit;
            cnd[g] = live;
            if (command.valid && command.write && int'(command.group) == g)
               case (command.select)
                  `SER_SEL_ENABLE: en[g] = command.data & m;
                  `SER_SEL_FALL_FILTER: fl[g] = command.data & m;
                  `SER_SEL_RISE_FILTER: rs[g] = command.data & m;
                  default: ;
               endcase
         end
         if (statusPreset) en[1] = 16'h0000;
      end
   end
   // ****************************************************************
   // Stimulus.
   // ****************************************************************
   // Sparse condition flips keep edges rare enough for reads to see them.
   task automatic drive(input logic [21:0] c, input logic p);
      opCondition <= opCondition ^ 16'($urandom & $urandom & $urandom);
      quesCondition <= quesCondition ^ 16'($urandom & $urandom & $urandom);
      command <= c;
      statusPreset <= p;
      @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      $display("errors %0d of %0d checks", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h9EDB4CB9));
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      drive({2'h3, 1'h1, 3'h1, 16'hFFFF}, 1'b1);
      drive({2'h2, 1'h1, 3'h1, 16'h0000}, 1'b0);
      drive({2'h3, 1'h0, 3'h1, 16'h0000}, 1'b0);
      repeat (4000) drive(22'($urandom), $urandom_range(0, 15) == 0);
      drive(22'h000000, 1'b0);
      tally_and_finish();
   end
   // A stuck run is cut off well past the expected 20 us of traffic.
   initial begin
      #60000;
      err_count++;
      tally_and_finish();
   end
endmodule

bind ser_status_event_reporting ser_status_monitor ser_status_monitor_i (
   .ref_clk(ref_clk), .reset_n(reset_n), .opCondition(opCondition),
   .quesCondition(quesCondition), .command(command),
   .statusPreset(statusPreset), .response(response),
   .summaryByte(summaryByte));
